// ### hw/apisr_framer.sv
// Status and response framer: builds transmit status, modem status and
// remote command response frames and streams them as bytes to the host.
// Assumes requests hold valid until taken, synchronous inputs, 100 MHz clk.
// Assumes the host may hold out_ready low at any byte of a frame.
//
// Notes on behaviour
// - Finished 64-bit or 16-bit address transmit yields a 0x89 frame.
// - Transmit status echoes the request id; id zero gives no frame.
// - Status 0x00 success, 0x01 retries expired, 0x02 channel busy.
// - Status 0x03 when an unpolled indirect transmission is purged.
// - Indirect transmission times out after 2.5 cyclic sleep periods.
// - Status 0x21 network ack failure, 0x22 end device not joined.
// - Status 0x31 internal error, 0x32 resources exhausted.
// - Status 0x74 when the payload is too large.
// - Broadcast destination never reports 0x01 or 0x21.
// - Modem status frame is type 0x8a with one status byte.
// - Modem code 0x00 hardware reset, 0x01 watchdog reset.
// - Code 0x02 associated, 0x03 disassociated or network not formed.
// - Code 0x06 network formed, 0x0d input voltage too high.
// - Power-up emits a modem status frame with code 0x00.
// - A remote command reply yields a 0x97 frame.
// - Remote response echoes the host's request id.
// - Bytes 5 to 12 carry the responder's 64-bit address.
// - Bytes 13 to 14 carry the responder's 16-bit address.
// - Bytes 15 and 16 carry the two-character command name.
// - Byte 17 is command status, 0 ok through 4 no response.
// - Bytes from 18 carry raw binary register value.
// - Several responses per request are each framed in turn.
`default_nettype none
`include "apisr_cfg.svh"

module apisr_framer #(
   parameter int MAXD        = 8,
   parameter int SP_HALF_CYC = 500
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    tx_valid,
   output logic                         tx_ready,
   input  wire logic [7:0]              tx_type,
   input  wire logic [7:0]              tx_fid,
   input  wire logic [63:0]             tx_dest,
   input  wire apisr_pkg::apisr_txc_e   tx_cause,
   input  wire logic                    ind_start,
   input  wire logic [7:0]              ind_fid,
   input  wire logic                    ind_poll,
   input  wire logic [15:0]             cyclic_sleep_period,
   input  wire logic                    rm_valid,
   output logic                         rm_ready,
   input  wire logic [7:0]              rm_fid,
   input  wire logic [63:0]             rm_src64,
   input  wire logic [15:0]             rm_src16,
   input  wire logic [15:0]             rm_cmd,
   input  wire logic [7:0]              rm_cstat,
   input  wire logic [7:0]              rm_len,
   input  wire logic [8*MAXD-1:0]       rm_data,
   input  wire logic                    md_valid,
   output logic                         md_ready,
   input  wire apisr_pkg::apisr_mdc_e   md_cause,
   output logic [7:0]                   out_data,
   output logic                         out_valid,
   input  wire logic                    out_ready
);
   import apisr_pkg::*;

   localparam int MAXB = 15 + MAXD;

   typedef struct packed {
      apisr_st_e              st;
      apisr_gnt_e             gnt;
      logic [MAXB-1:0][7:0]   body;
      logic [7:0]             len;
      logic [7:0]             idx;
      logic [7:0]             sum;
      logic                   pwr_pend;
      logic                   ind_act;
      logic [7:0]             ind_id;
      logic [15:0]            pre;
      logic [18:0]            halves;
      logic                   to_pend;
      logic [7:0]             to_id;
      logic                   tx_rdy;
      logic                   rm_rdy;
      logic                   md_rdy;
   } apisr_frm_s;

   apisr_frm_s   st_r;
   apisr_frm_s   st_nxt;
   apisr_byte_if bif ();
   logic [18:0]  to_limit;
   logic         tx_take;
   logic         rm_take;
   logic         md_take;

   // ----------------------------------------------------------------------
   // Code mapping
   // ----------------------------------------------------------------------
   // Broadcast folds both acknowledgement failures into success
   function automatic logic [7:0] tx_code(apisr_txc_e c, logic bc);
      case (c)
         TXC_OK:     tx_code = `APISR_TS_OK;
         TXC_NOACK:  tx_code = bc ? `APISR_TS_OK
                                  : `APISR_TS_NOACK;
         TXC_CCA:    tx_code = `APISR_TS_CCA;
         TXC_NETACK: tx_code = bc ? `APISR_TS_OK
                                  : `APISR_TS_NETACK;
         TXC_NOJOIN: tx_code = `APISR_TS_NOJOIN;
         TXC_INTERR: tx_code = `APISR_TS_INTERR;
         TXC_NORES:  tx_code = `APISR_TS_NORES;
         default:    tx_code = `APISR_TS_TOOBIG;
      endcase
   endfunction : tx_code

   function automatic logic [7:0] md_code(apisr_mdc_e c);
      case (c)
         MDC_HWRST:  md_code = `APISR_MS_HWRST;
         MDC_WDRST:  md_code = `APISR_MS_WDRST;
         MDC_ASSOC:  md_code = `APISR_MS_ASSOC;
         MDC_DISASC: md_code = `APISR_MS_DISASC;
         MDC_FORMED: md_code = `APISR_MS_FORMED;
         default:    md_code = `APISR_MS_OVERV;
      endcase
   endfunction : md_code

   // ----------------------------------------------------------------------
   // Request acceptance
   // ----------------------------------------------------------------------
   // Readies come from flops, so one grant cycle precedes each take
   assign tx_ready = st_r.tx_rdy;
   assign rm_ready = st_r.rm_rdy;
   assign md_ready = st_r.md_rdy;
   assign tx_take  = tx_valid && st_r.tx_rdy;
   assign rm_take  = rm_valid && st_r.rm_rdy;
   assign md_take  = md_valid && st_r.md_rdy;
   // 19 bits hold the largest period times five halves without wrap
   assign to_limit = 19'(cyclic_sleep_period) * 19'(`APISR_TO_HALVES);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [7:0] n;
      logic [7:0] b;
      logic       to_fire;
      n      = 8'h00;
      b      = 8'h00;
      to_fire = 1'b0;
      st_nxt = st_r;
      st_nxt.tx_rdy = 1'b0;
      st_nxt.rm_rdy = 1'b0;
      st_nxt.md_rdy = 1'b0;

      // Indirect timeout: counts half periods up to 5 x period
      if (ind_start) begin
         st_nxt.ind_act = 1'b1;
         st_nxt.ind_id  = ind_fid;
         st_nxt.pre     = '0;
         st_nxt.halves  = '0;
      end else if (ind_poll) begin
         st_nxt.ind_act = 1'b0;
      end else if (st_r.ind_act) begin
         if (st_r.halves >= to_limit) begin
            st_nxt.ind_act = 1'b0;
            if (st_r.ind_id != 8'h00) begin
               st_nxt.to_pend = 1'b1;
               to_fire        = 1'b1;
               st_nxt.to_id   = st_r.ind_id;
            end
         end else if (st_r.pre == 16'(SP_HALF_CYC - 1)) begin
            st_nxt.pre    = '0;
            st_nxt.halves = st_r.halves + 19'h1;
         end else begin
            st_nxt.pre = st_r.pre + 16'h1;
         end
      end

      case (st_r.st)
         ST_IDLE: begin
            // Internal events first: they have no way to be held off
            if (st_r.to_pend) begin
               // A timeout firing now must not be lost to this clear
               st_nxt.to_pend = to_fire;
               st_nxt.body[0] = `APISR_T_TXST;
               st_nxt.body[1] = st_r.to_id;
               st_nxt.body[2] = `APISR_TS_PURGED;
               st_nxt.len     = `APISR_LEN_TXST;
               st_nxt.st      = ST_SOF;
            end else if (st_r.pwr_pend) begin
               // Owed once after each reset, ahead of any request
               st_nxt.pwr_pend = 1'b0;
               st_nxt.body[0]  = `APISR_T_MODEM;
               st_nxt.body[1]  = `APISR_MS_HWRST;
               st_nxt.len      = `APISR_LEN_MODEM;
               st_nxt.st       = ST_SOF;
            end else if (tx_valid) begin
               st_nxt.gnt    = G_TX;
               st_nxt.tx_rdy = 1'b1;
               st_nxt.st     = ST_GRANT;
            end else if (rm_valid) begin
               st_nxt.gnt    = G_RM;
               st_nxt.rm_rdy = 1'b1;
               st_nxt.st     = ST_GRANT;
            end else if (md_valid) begin
               st_nxt.gnt    = G_MD;
               st_nxt.md_rdy = 1'b1;
               st_nxt.st     = ST_GRANT;
            end
         end

         ST_GRANT: begin
            st_nxt.st  = ST_IDLE;
            st_nxt.gnt = G_NONE;
            if (tx_take) begin
               // Only finished 0x00/0x01 requests with nonzero id report
               if ((tx_type == `APISR_REQ64 || tx_type == `APISR_REQ16)
                   && tx_fid != 8'h00) begin
                  st_nxt.body[0] = `APISR_T_TXST;
                  st_nxt.body[1] = tx_fid;
                  st_nxt.body[2] = tx_code(tx_cause,
                                   tx_dest == `APISR_BCAST);
                  st_nxt.len     = `APISR_LEN_TXST;
                  st_nxt.st      = ST_SOF;
               end
            end else if (rm_take) begin
               // Data past MAXD bytes is cut; the length says what went
               n = (rm_len > 8'(MAXD)) ? 8'(MAXD) : rm_len;
               st_nxt.body[0] = `APISR_T_RMTRSP;
               st_nxt.body[1] = rm_fid;
               for (int i = 0; i < 8; i++) begin
                  st_nxt.body[2+i] = rm_src64[63-8*i -: 8];
               end
               st_nxt.body[10] = rm_src16[15:8];
               st_nxt.body[11] = rm_src16[7:0];
               st_nxt.body[12] = rm_cmd[15:8];
               st_nxt.body[13] = rm_cmd[7:0];
               st_nxt.body[14] = (rm_cstat > `APISR_CST_MAX)
                                 ? 8'h01 : rm_cstat;
               for (int i = 0; i < MAXD; i++) begin
                  st_nxt.body[15+i] = rm_data[8*i +: 8];
               end
               st_nxt.len = `APISR_LEN_RMHDR + n;
               st_nxt.st  = ST_SOF;
            end else if (md_take) begin
               st_nxt.body[0] = `APISR_T_MODEM;
               st_nxt.body[1] = md_code(md_cause);
               st_nxt.len     = `APISR_LEN_MODEM;
               st_nxt.st      = ST_SOF;
            end
         end

         ST_SOF: begin
            // Index and sum restart, so no frame inherits the last one's
            if (bif.ready) begin
               st_nxt.st  = ST_LENH;
               st_nxt.idx = 8'h00;
               st_nxt.sum = 8'h00;
            end
         end

         ST_LENH: begin
            // Frames stay under 256 data bytes: high length byte is 0
            if (bif.ready) begin
               st_nxt.st = ST_LENL;
            end
         end

         ST_LENL: begin
            if (bif.ready) begin
               st_nxt.st = ST_BODY;
            end
         end

         ST_BODY: begin
            // Checksum covers the frame data bytes only
            if (bif.ready) begin
               b          = st_r.body[st_r.idx];
               st_nxt.sum = st_r.sum + b;
               st_nxt.idx = st_r.idx + 8'h1;
               if (st_r.idx == st_r.len - 8'h1) begin
                  st_nxt.st = ST_CSUM;
               end
            end
         end

         ST_CSUM: begin
            // Next grant waits until the checksum is in the buffer
            if (bif.ready) begin
               st_nxt.st = ST_IDLE;
            end
         end
         default: begin
            st_nxt.st = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Byte source toward the buffer
   // ----------------------------------------------------------------------
   always_comb begin
      bif.valid = 1'b1;
      case (st_r.st)
         ST_SOF:  bif.data = `APISR_SOF;
         ST_LENH: bif.data = 8'h00;
         ST_LENL: bif.data = st_r.len;
         ST_BODY: bif.data = st_r.body[st_r.idx];
         ST_CSUM: bif.data = `APISR_CSUM_BASE - st_r.sum;
         default: begin
            bif.data  = 8'h00;
            bif.valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r          <= '0;
         st_r.st       <= ST_IDLE;
         st_r.gnt      <= G_NONE;
         // A power-up report is owed after every reset
         st_r.pwr_pend <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Output buffer
   // ----------------------------------------------------------------------
   // Two entries let the host stall at any byte with nothing lost
   apisr_buf u_buf (
      .clk       (clk),
      .rst       (rst),
      .in_if     (bif),
      .out_data  (out_data),
      .out_valid (out_valid),
      .out_ready (out_ready)
   );
endmodule : apisr_framer

`default_nettype wire

// ### hw/apisr_cfg.svh
// Constants of the API status and response framer: frame codes, offsets,
// status encodings and fixed bytes.
// Assumes inclusion by bare name from the framer's design files.
`ifndef APISR_CFG_SVH
`define APISR_CFG_SVH

// ----------------------------------------------------------------------
// Framing
// ----------------------------------------------------------------------
`define APISR_SOF        8'h7e
`define APISR_CSUM_BASE  8'hff
`define APISR_OFS_TYPE   3
`define APISR_OFS_FID    4

// ----------------------------------------------------------------------
// Frame types
// ----------------------------------------------------------------------
`define APISR_REQ64      8'h00
`define APISR_REQ16      8'h01
`define APISR_T_TXST     8'h89
`define APISR_T_MODEM    8'h8a
`define APISR_T_RMTRSP   8'h97
`define APISR_LEN_TXST   8'h03
`define APISR_LEN_MODEM  8'h02
`define APISR_LEN_RMHDR  8'h0f

// ----------------------------------------------------------------------
// Transmit status codes
// ----------------------------------------------------------------------
`define APISR_TS_OK      8'h00
`define APISR_TS_NOACK   8'h01
`define APISR_TS_CCA     8'h02
`define APISR_TS_PURGED  8'h03
`define APISR_TS_NETACK  8'h21
`define APISR_TS_NOJOIN  8'h22
`define APISR_TS_INTERR  8'h31
`define APISR_TS_NORES   8'h32
`define APISR_TS_TOOBIG  8'h74
`define APISR_BCAST      64'h0000_0000_0000_ffff

// ----------------------------------------------------------------------
// Modem status codes and timeout factor (2.5 = 5 half periods)
// ----------------------------------------------------------------------
`define APISR_MS_HWRST   8'h00
`define APISR_MS_WDRST   8'h01
`define APISR_MS_ASSOC   8'h02
`define APISR_MS_DISASC  8'h03
`define APISR_MS_FORMED  8'h06
`define APISR_MS_OVERV   8'h0d
`define APISR_TO_HALVES  3'h5
`define APISR_CST_MAX    8'h04

`endif

// ### hw/apisr_pkg.sv
// Types shared by the framer and its output buffer.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package apisr_pkg;
   typedef enum logic [2:0] {
      TXC_OK, TXC_NOACK, TXC_CCA, TXC_NETACK,
      TXC_NOJOIN, TXC_INTERR, TXC_NORES, TXC_TOOBIG
   } apisr_txc_e;

   typedef enum logic [2:0] {
      MDC_HWRST, MDC_WDRST, MDC_ASSOC, MDC_DISASC, MDC_FORMED, MDC_OVERV
   } apisr_mdc_e;

   typedef enum logic [2:0] {
      ST_IDLE, ST_GRANT, ST_SOF, ST_LENH, ST_LENL, ST_BODY, ST_CSUM
   } apisr_st_e;

   typedef enum logic [1:0] {G_NONE, G_TX, G_RM, G_MD} apisr_gnt_e;
endpackage : apisr_pkg

`default_nettype wire

// ### hw/apisr_byte_if.sv
// Byte stream carrier between the framer core and its output buffer.
// Assumes both ends run on the same clock.
`default_nettype none

interface apisr_byte_if;
   logic [7:0] data;
   logic       valid;
   logic       ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : apisr_byte_if

`default_nettype wire

// ### hw/apisr_buf.sv
// Two-entry output buffer of the framer.
// Assumes a synchronous active-high reset and a receiver that may stall.
`default_nettype none
`include "apisr_cfg.svh"

module apisr_buf (
   input  wire logic   clk,
   input  wire logic   rst,
   apisr_byte_if.snk   in_if,
   output logic [7:0]  out_data,
   output logic        out_valid,
   input  wire logic   out_ready
);
   import apisr_pkg::*;

   typedef struct packed {
      logic [7:0] d0;
      logic [7:0] d1;
      logic       v0;
      logic       v1;
   } apisr_buf_s;

   apisr_buf_s st_r;
   apisr_buf_s st_nxt;
   logic       push;
   logic       pop;

   // Ready drops only when both entries hold, so a stall loses no byte
   assign in_if.ready = !st_r.v1;
   assign push        = in_if.valid && !st_r.v1;
   assign pop         = st_r.v0 && out_ready;
   assign out_data    = st_r.d0;
   assign out_valid   = st_r.v0;

   always_comb begin
      st_nxt = st_r;
      if (pop && push) begin
         if (st_r.v1) begin
            st_nxt.d0 = st_r.d1;
            st_nxt.d1 = in_if.data;
         end else begin
            st_nxt.d0 = in_if.data;
         end
      end else if (pop) begin
         st_nxt.d0 = st_r.d1;
         st_nxt.v0 = st_r.v1;
         st_nxt.v1 = 1'b0;
      end else if (push) begin
         if (!st_r.v0) begin
            st_nxt.d0 = in_if.data;
            st_nxt.v0 = 1'b1;
         end else begin
            st_nxt.d1 = in_if.data;
            st_nxt.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : apisr_buf

`default_nettype wire

// ### verification/apisr_checker.sv
// Checker of the framer's output stream and its grants.
// Assumes a bind onto the framer top, every port by name.
`default_nettype none

module apisr_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       tx_valid,
   input wire logic       tx_ready,
   input wire logic       rm_ready,
   input wire logic       md_ready,
   input wire logic [7:0] out_data,
   input wire logic       out_valid,
   input wire logic       out_ready
);
   // ----------
   // Frame tracker
   // ----------
   logic [7:0] idx_r;
   logic [7:0] len_r;
   logic [7:0] sum_r;
   logic       acc;
   logic       last;
   logic       gnt;
   assign acc  = out_valid && out_ready;
   assign last = idx_r > 8'h04 && idx_r == len_r + 8'h03;
   assign gnt  = tx_ready || rm_ready || md_ready;
   always_ff @(posedge clk) begin
      if (rst) begin
         idx_r <= 8'h00;
         len_r <= 8'h00;
         sum_r <= 8'h00;
      end else if (acc) begin
         idx_r <= last ? 8'h00 : idx_r + 8'h01;
         if (idx_r == 8'h02) len_r <= out_data;
         sum_r <= (idx_r < 8'h03) ? 8'h00 : sum_r + out_data;
      end
   end
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_sof_first: assert property (
      acc && idx_r == 8'h00 |-> out_data == 8'h7e) else $error("bad start");
   a_len_high: assert property (
      acc && idx_r == 8'h01 |-> out_data == 8'h00) else $error("bad length");
   a_csum_match: assert property (
      acc && last |-> out_data == 8'hff - sum_r) else $error("bad checksum");
   a_txst_len: assert property (
      acc && idx_r == 8'h03 && out_data == 8'h89 |-> len_r == 8'h03)
      else $error("bad tx status length");
   a_modem_len: assert property (
      acc && idx_r == 8'h03 && out_data == 8'h8a |-> len_r == 8'h02)
      else $error("bad modem length");
   a_rmt_len: assert property (
      acc && idx_r == 8'h03 && out_data == 8'h97 |->
      len_r >= 8'h0f && len_r <= 8'h17) else $error("bad remote length");
   a_stall_hold: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("byte lost in stall");
   a_grant_pulse: assert property (
      gnt |-> $onehot({tx_ready, rm_ready, md_ready}) ##1 !gnt)
      else $error("grant not a single pulse");
   a_grant_cause: assert property (
      tx_ready |-> $past(tx_valid)) else $error("grant without request");
   a_powerup_frame: assert property (
      $fell(rst) |-> ##[2:6] (out_valid && out_data == 8'h7e))
      else $error("no power-up frame");
   c_tx: cover property (tx_ready);
   c_rm: cover property (rm_ready);
   c_stall: cover property (out_valid && !out_ready);
endmodule : apisr_checker

`default_nettype wire

// ### verification/apisr_host_model.sv
// Host model: takes frame bytes, stalls on request, keeps last frame.
// Assumes the framer streams whole frames that begin with 0x7e.
`default_nettype none

module apisr_host_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       stall,
   input  wire logic [7:0] out_data,
   input  wire logic       out_valid,
   output logic            out_ready,
   output logic            done
);
   logic [7:0] fb [0:31];
   logic [7:0] len_r;
   logic [1:0] cyc_r;
   int         n_r;
   // Slow host ready one cycle in four, so the buffer fills and refuses
   assign out_ready = !stall || cyc_r == 2'b00;
   // Every frame is taken in turn, several per request too
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (rst) begin
         n_r   <= 0;
         cyc_r <= 2'b00;
      end else begin
         cyc_r <= cyc_r + 2'b01;
         if (out_valid && out_ready) begin
            if (n_r == 2) len_r <= out_data;
            if (n_r < 32) fb[n_r] <= out_data;
            if (n_r > 4 && n_r == len_r + 3) begin
               done <= 1'b1;
               n_r  <= 0;
            end else begin
               n_r <= n_r + 1;
            end
         end
      end
   end
endmodule : apisr_host_model

`default_nettype wire

// ### verification/api_status_response_framer_tb_top.sv
// Bench of the status and response framer against a host model.
// Assumes design, checker and host model are compiled before it.
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module api_status_response_framer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import apisr_pkg::*;
   localparam int MD = 8;
   logic            clk = 1'b0, rst = 1'b1, stall = 1'b0;
   logic            ind_start = 1'b0, ind_poll = 1'b0;
   logic [2:0]      vld = 3'b000;
   logic [2:0]      rdy;
   logic            done, out_valid, out_ready;
   logic [7:0]      out_data, tx_type = 8'h00, tx_fid = 8'h00;
   logic [7:0]      ind_fid = 8'h00, rm_fid = 8'h00, rm_cstat = 8'h00;
   logic [7:0]      rm_len = 8'h00;
   logic [63:0]     tx_dest = 64'h0, rm_src64 = 64'h0;
   logic [15:0]     csp = 16'h0002, rm_src16 = 16'h0, rm_cmd = 16'h0;
   logic [8*MD-1:0] rm_data = '0;
   apisr_txc_e      tx_cause = TXC_OK;
   apisr_mdc_e      md_cause = MDC_HWRST;
   logic [31:0]     seed = 32'h4cd8;
   logic [7:0]      q[$];
   int              fail_count = 0, total_checks = 0, c, t0;
   int              lens[6] = '{0, MD, 3, 12, 5, 1};

   apisr_framer #(.MAXD(MD), .SP_HALF_CYC(2)) DUT (
      .clk(clk), .rst(rst), .tx_valid(vld[0]), .tx_ready(rdy[0]),
      .tx_type(tx_type), .tx_fid(tx_fid), .tx_dest(tx_dest),
      .tx_cause(tx_cause), .ind_start(ind_start), .ind_fid(ind_fid),
      .ind_poll(ind_poll), .cyclic_sleep_period(csp),
      .rm_valid(vld[1]), .rm_ready(rdy[1]), .rm_fid(rm_fid),
      .rm_src64(rm_src64), .rm_src16(rm_src16), .rm_cmd(rm_cmd),
      .rm_cstat(rm_cstat), .rm_len(rm_len), .rm_data(rm_data),
      .md_valid(vld[2]), .md_ready(rdy[2]), .md_cause(md_cause),
      .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
   apisr_host_model u_host (
      .clk(clk), .rst(rst), .stall(stall), .out_data(out_data),
      .out_valid(out_valid), .out_ready(out_ready), .done(done));

   function automatic logic [31:0] nx(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nx
   // Broadcast hides the two acknowledgement failures
   function automatic logic [7:0] ts_exp(int k, bit bc);
      logic [7:0] t[8] = '{8'h00, 8'h01, 8'h02, 8'h21,
                           8'h22, 8'h31, 8'h32, 8'h74};
      return (bc && (k == 1 || k == 3)) ? 8'h00 : t[k];
   endfunction : ts_exp

   task automatic grant(int k);
      int i;
      vld[k] = 1'b1;
      for (i = 0; i < 300; i++) begin
         @(posedge clk);
         if (rdy[k] === 1'b1) break;
      end
      #1 vld[k] = 1'b0;
      `CHK("grant", 1, i < 300)
   endtask : grant
   task automatic expect_frame();
      int i, k;
      logic [7:0] s;
      for (i = 0; i < 2000; i++) begin
         @(posedge clk);
         if (done === 1'b1) break;
      end
      `CHK("frame", 1, i < 2000)
      `CHK("sof", 8'h7e, u_host.fb[0])
      `CHK("len", {8'h00, 8'(q.size())}, {u_host.fb[1], u_host.fb[2]})
      s = 8'h00;
      for (k = 0; k < q.size(); k++) begin
         `CHK("byte", q[k], u_host.fb[3 + k])
         s += q[k];
      end
      `CHK("csum", 8'hff - s, u_host.fb[3 + q.size()])
   endtask : expect_frame
   task automatic quiet(int n);
      int i, seen;
      seen = 0;
      for (i = 0; i < n; i++) begin
         @(posedge clk);
         if (done !== 1'b0) seen++;
      end
      `CHK("quiet", 0, seen)
   endtask : quiet
   task automatic send_tx(logic [7:0] ty, logic [7:0] id, int k, bit bc);
      @(posedge clk);
      #1 tx_type = ty;
      tx_fid = id;
      tx_cause = apisr_txc_e'(k);
      tx_dest = bc ? 64'h0000_0000_0000_ffff : {seed, ~seed};
      grant(0);
      q = {8'h89, id, ts_exp(k, bc)};
   endtask : send_tx
   task automatic send_rm(int n, logic [7:0] cs);
      int k;
      @(posedge clk);
      #1 rm_fid = seed[7:0];
      rm_src64 = {seed, ~seed};
      rm_src16 = seed[23:8];
      rm_cmd = seed[31:16];
      rm_cstat = cs;
      rm_len = 8'(n);
      rm_data = {seed ^ 32'h5a3c, seed};
      grant(1);
      q = {8'h97, rm_fid};
      for (k = 7; k >= 0; k--) q.push_back(rm_src64[8*k+:8]);
      q.push_back(rm_src16[15:8]);
      q.push_back(rm_src16[7:0]);
      q.push_back(rm_cmd[15:8]);
      q.push_back(rm_cmd[7:0]);
      q.push_back(cs > 8'h04 ? 8'h01 : cs);
      for (k = 0; k < n && k < MD; k++) q.push_back(rm_data[8*k+:8]);
   endtask : send_rm
   task automatic report_and_stop();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      #500000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      q = {8'h8a, 8'h00};
      expect_frame();
      for (c = 0; c < 16; c++) begin
         seed = nx(seed);
         #1 stall = seed[0];
         send_tx({7'h00, seed[1]}, {seed[9:3], 1'b1}, c % 8, c > 7);
         expect_frame();
      end
      send_tx(8'h00, 8'h00, 0, 0);
      send_tx(8'h08, 8'h11, 0, 0);
      quiet(40);
      for (c = 0; c < 6; c++) begin
         @(posedge clk);
         #1 md_cause = apisr_mdc_e'(c);
         grant(2);
         q = {8'h8a, c < 4 ? 8'(c) : (c == 4 ? 8'h06 : 8'h0d)};
         expect_frame();
      end
      #1 stall = 1'b1;
      for (c = 0; c < 6; c++) begin
         seed = nx(seed);
         send_rm(lens[c], c > 4 ? 8'h07 : 8'(c));
         expect_frame();
      end
      #1 stall = 1'b0;
      @(posedge clk);
      #1 ind_fid = 8'h5c;
      ind_start = 1'b1;
      t0 = $time;
      @(posedge clk);
      #1 ind_start = 1'b0;
      quiet(15);
      q = {8'h89, 8'h5c, 8'h03};
      expect_frame();
      `CHK("tmo", 1, ($time - t0) / 10 inside {[25:45]})
      @(posedge clk);
      #1 ind_start = 1'b1;
      @(posedge clk);
      #1 ind_start = 1'b0;
      ind_poll = 1'b1;
      @(posedge clk);
      #1 ind_poll = 1'b0;
      quiet(60);
      report_and_stop();
   end
endmodule : api_status_response_framer_tb_top

bind apisr_framer apisr_checker u_chk (
   .clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .rm_ready(rm_ready), .md_ready(md_ready), .out_data(out_data),
   .out_valid(out_valid), .out_ready(out_ready));

`default_nettype wire
